// file: pkg/asp_pkg.sv
// Shared constants and types for the asynchronous serial port block.
package asp_pkg;

	// Register byte offsets on the APB.
	localparam int          ADDR_W   = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_TCFG = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;

	// Serial control register bit positions.
	localparam int CTL_MODE = 7;
	localparam int CTL_ONE  = 6;
	localparam int CTL_MCE  = 5;
	localparam int CTL_REN  = 4;
	localparam int CTL_TB8  = 3;
	localparam int CTL_RB8  = 2;
	localparam int CTL_TXD  = 1;
	localparam int CTL_RXD  = 0;

	// Timer configuration register field positions.
	localparam int TCFG_RUN = 8;
	localparam int TCFG_SRC = 9;
	localparam int TCFG_IE  = 12;

	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h40;
	localparam logic [7:0] DATA_RST = 8'h00;

	// Prescaler terminal counts (divide value minus one per stage).
	localparam logic [1:0] PRE4_LAST  = 2'h3;
	localparam logic [1:0] PRE3_LAST  = 2'h2;
	localparam logic [1:0] PRE12_LAST = 2'h3;
	localparam logic [2:0] EXT8_LAST  = 3'h7;

	// Character lengths in bit times, start and stop included.
	localparam logic [3:0] FRAME8 = 4'ha;
	localparam logic [3:0] FRAME9 = 4'hb;

	// Timer one clock sources.
	typedef enum logic [2:0] {
		SRC_SYS   = 3'h0,
		SRC_DIV4  = 3'h1,
		SRC_DIV12 = 3'h2,
		SRC_DIV48 = 3'h3,
		SRC_EXT8  = 3'h4,
		SRC_PIN   = 3'h5
	} asp_src_t;

	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} asp_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} asp_rx_st_t;

	// APB request and response groups.
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} asp_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} asp_apb_rsp_t;

endpackage

// file: src/asp_reload_timer.sv
// Eight-bit auto-reload counter used for the transmit and receive timers.
`timescale 1ns/10ps
module asp_reload_timer #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         tick_i,
	input  wire logic         force_i,
	input  wire logic [W-1:0] reload_i,
	output logic      [W-1:0] count_o,
	output logic              ovf_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         ovf;
	} asp_tmr_state_t;

	asp_tmr_state_t st_q;
	asp_tmr_state_t st_d;

	// A forced reload beats a tick, so an overflow never leaks past it.
	always_comb
	begin
		st_d = st_q;
		st_d.ovf = 1'b0;
		if (force_i)
			st_d.cnt = reload_i;
		else if (tick_i)
		begin
			if (&st_q.cnt)
			begin
				st_d.cnt = reload_i;
				st_d.ovf = 1'b1;
			end
			else
				st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign count_o = st_q.cnt;
	assign ovf_o   = st_q.ovf;

	a_ovf_reload: assert property (@(posedge clk_i) disable iff (reset_i)
		ovf_o |-> count_o == $past(reload_i))
		else $error("Counter did not reload on overflow.");
endmodule

// file: src/asp_top.sv
// Asynchronous serial port with timer baud generation, APB registers.
`timescale 1ns/10ps
module asp_top (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire asp_pkg::asp_apb_req_t apb_i,
	output asp_pkg::asp_apb_rsp_t      apb_o,
	input  wire logic                  rxd_i,
	output logic                       txd_o,
	input  wire logic                  ext_osc_i,
	input  wire logic                  timer_one_ext_input_i,
	output logic                       irq_o
);
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [7:0]            rbuf;
		logic [7:0]            reload;
		logic                  run;
		asp_pkg::asp_src_t     src;
		logic                  ie;
		logic [1:0]            p4;
		logic [1:0]            p3;
		logic [1:0]            p12;
		logic [2:0]            ecnt;
		logic                  osc1;
		logic                  osc2;
		logic                  osc3;
		logic                  pin1;
		logic                  pin2;
		logic                  pin3;
		logic                  rx1;
		logic                  rx2;
		logic                  rx3;
		logic                  txdiv;
		asp_pkg::asp_tx_st_t   tx_st;
		logic [10:0]           tx_sh;
		logic [3:0]            tx_cnt;
		logic                  txd;
		asp_pkg::asp_rx_st_t   rx_st;
		logic                  rx_ph;
		logic [10:0]           rx_sh;
		logic [3:0]            rx_cnt;
		asp_pkg::asp_apb_rsp_t rsp;
		logic                  irq;
	} asp_top_state_t;

	asp_top_state_t st_q;
	asp_top_state_t st_d;

	logic        acc;
	logic        commit;
	logic        hit;
	logic        wr_ctrl;
	logic        wr_data;
	logic        wr_tcfg;
	logic        d4;
	logic        d12;
	logic        d48;
	logic        e8;
	logic        pin_fall;
	logic        src_tick;
	logic        rx_fall;
	logic        rx_force;
	logic        tx_ovf;
	logic        rx_ovf;
	logic        tx_bit;
	logic [7:0]  tx_count;
	logic [7:0]  rx_count;
	logic [3:0]  nbits;
	logic        mode9;
	logic [10:0] sh_n;

	// Bus decode; a write lands only at the edge where pready is seen high.
	assign acc     = apb_i.psel & apb_i.penable;
	assign commit  = acc & st_q.rsp.pready;
	assign hit     = apb_i.paddr == asp_pkg::OFS_CTRL
		|| apb_i.paddr == asp_pkg::OFS_DATA
		|| apb_i.paddr == asp_pkg::OFS_TCFG
		|| apb_i.paddr == asp_pkg::OFS_STAT;
	assign wr_ctrl = commit & apb_i.pwrite
		& (apb_i.paddr == asp_pkg::OFS_CTRL);
	assign wr_data = commit & apb_i.pwrite
		& (apb_i.paddr == asp_pkg::OFS_DATA);
	assign wr_tcfg = commit & apb_i.pwrite
		& (apb_i.paddr == asp_pkg::OFS_TCFG);

	// Timer clock sources; edges are taken only from synchronised copies.
	assign d4       = st_q.p4 == asp_pkg::PRE4_LAST;
	assign d12      = d4 & (st_q.p3 == asp_pkg::PRE3_LAST);
	assign d48      = d12 & (st_q.p12 == asp_pkg::PRE12_LAST);
	assign e8       = st_q.osc2 & ~st_q.osc3
		& (st_q.ecnt == asp_pkg::EXT8_LAST);
	assign pin_fall = ~st_q.pin2 & st_q.pin3;
	assign src_tick = st_q.run & (
		st_q.src == asp_pkg::SRC_SYS   ? 1'b1 :
		st_q.src == asp_pkg::SRC_DIV4  ? d4 :
		st_q.src == asp_pkg::SRC_DIV12 ? d12 :
		st_q.src == asp_pkg::SRC_DIV48 ? d48 :
		st_q.src == asp_pkg::SRC_EXT8  ? e8 :
		st_q.src == asp_pkg::SRC_PIN   ? pin_fall : 1'b0);

	// Start detection on the synchronised receive line.
	assign rx_fall  = ~st_q.rx2 & st_q.rx3;
	assign rx_force = (st_q.rx_st == asp_pkg::RX_IDLE)
		& st_q.ctrl[asp_pkg::CTL_REN] & rx_fall;

	assign mode9  = st_q.ctrl[asp_pkg::CTL_MODE];
	assign nbits  = mode9 ? asp_pkg::FRAME9 : asp_pkg::FRAME8;
	assign tx_bit = tx_ovf & st_q.txdiv;
	assign sh_n   = {st_q.rx2, st_q.rx_sh[10:1]};

	// Transmit timer is the visible low counter.
	asp_reload_timer #(.W(8)) u_tx_tmr (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.tick_i   (src_tick),
		.force_i  (1'b0),
		.reload_i (st_q.reload),
		.count_o  (tx_count),
		.ovf_o    (tx_ovf)
	);

	// Receive timer is a hidden copy on the same clock and reload byte.
	asp_reload_timer #(.W(8)) u_rx_tmr (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.tick_i   (src_tick),
		.force_i  (rx_force),
		.reload_i (st_q.reload),
		.count_o  (rx_count),
		.ovf_o    (rx_ovf)
	);

	// Next state of the whole block.
	always_comb
	begin
		logic [31:0] rdata;
		logic        tx_set;
		logic        rx_set;
		logic        chk;
		rdata  = 32'h0;
		tx_set = 1'b0;
		rx_set = 1'b0;
		chk    = mode9 ? sh_n[9] : sh_n[10];
		st_d   = st_q;

		// Synchronisers and prescalers.
		st_d.osc1 = ext_osc_i;
		st_d.osc2 = st_q.osc1;
		st_d.osc3 = st_q.osc2;
		st_d.pin1 = timer_one_ext_input_i;
		st_d.pin2 = st_q.pin1;
		st_d.pin3 = st_q.pin2;
		st_d.rx1  = rxd_i;
		st_d.rx2  = st_q.rx1;
		st_d.rx3  = st_q.rx2;
		st_d.p4   = st_q.p4 + 2'h1;
		if (d4)
			st_d.p3 = (st_q.p3 == asp_pkg::PRE3_LAST) ? 2'h0
				: st_q.p3 + 2'h1;
		if (d12)
			st_d.p12 = st_q.p12 + 2'h1;
		if (st_q.osc2 & ~st_q.osc3)
			st_d.ecnt = st_q.ecnt + 3'h1;

		// Read mux; the transmit shifter is deliberately not visible.
		case (apb_i.paddr)
			asp_pkg::OFS_CTRL: rdata = {24'h0, st_q.ctrl};
			asp_pkg::OFS_DATA: rdata = {24'h0, st_q.rbuf};
			asp_pkg::OFS_TCFG: rdata = {19'h0, st_q.ie, st_q.src,
				st_q.run, st_q.reload};
			asp_pkg::OFS_STAT: rdata = {22'h0,
				st_q.rx_st == asp_pkg::RX_BUSY,
				st_q.tx_st == asp_pkg::TX_SEND, tx_count};
			default: rdata = 32'h0;
		endcase

		// One wait state: pready rises in the second access cycle.
		st_d.rsp.pready  = acc & ~st_q.rsp.pready;
		st_d.rsp.pslverr = acc & ~st_q.rsp.pready & ~hit;
		st_d.rsp.prdata  = (acc & ~st_q.rsp.pready) ? rdata : 32'h0;

		// Software register writes.
		if (wr_ctrl)
			st_d.ctrl = {apb_i.pwdata[7], 1'b1, apb_i.pwdata[5:0]};
		if (wr_tcfg)
		begin
			st_d.reload = apb_i.pwdata[7:0];
			st_d.run    = apb_i.pwdata[asp_pkg::TCFG_RUN];
			st_d.src    = asp_pkg::asp_src_t'(
				apb_i.pwdata[asp_pkg::TCFG_SRC +: 3]);
			st_d.ie     = apb_i.pwdata[asp_pkg::TCFG_IE];
		end

		// Transmitter; a data write restarts the frame even mid-send.
		if (tx_ovf)
			st_d.txdiv = ~st_q.txdiv;
		if (wr_data)
		begin
			st_d.tx_sh  = {1'b1,
				mode9 ? st_q.ctrl[asp_pkg::CTL_TB8] : 1'b1,
				apb_i.pwdata[7:0], 1'b0};
			st_d.tx_cnt = 4'h0;
			st_d.tx_st  = asp_pkg::TX_SEND;
		end
		else
		begin
			case (st_q.tx_st)
				asp_pkg::TX_IDLE: st_d.txd = 1'b1;
				asp_pkg::TX_SEND:
				begin
					if (tx_bit)
					begin
						if (st_q.tx_cnt == nbits)
							st_d.tx_st = asp_pkg::TX_IDLE;
						else
						begin
							st_d.txd    = st_q.tx_sh[0];
							st_d.tx_sh  = {1'b1, st_q.tx_sh[10:1]};
							st_d.tx_cnt = st_q.tx_cnt + 4'h1;
							tx_set = st_q.tx_cnt == nbits - 4'h1;
						end
					end
				end
				default: st_d.tx_st = asp_pkg::TX_IDLE;
			endcase
		end

		// Receiver; first overflow after the reload is mid start bit.
		case (st_q.rx_st)
			asp_pkg::RX_IDLE:
			begin
				if (rx_force)
				begin
					st_d.rx_st  = asp_pkg::RX_BUSY;
					st_d.rx_ph  = 1'b0;
					st_d.rx_cnt = 4'h0;
				end
			end
			asp_pkg::RX_BUSY:
			begin
				if (!st_q.ctrl[asp_pkg::CTL_REN])
					st_d.rx_st = asp_pkg::RX_IDLE;
				else if (rx_ovf)
				begin
					st_d.rx_ph = ~st_q.rx_ph;
					if (!st_q.rx_ph)
					begin
						st_d.rx_sh  = sh_n;
						st_d.rx_cnt = st_q.rx_cnt + 4'h1;
						if (st_q.rx_cnt == 4'h0 && st_q.rx2)
							st_d.rx_st = asp_pkg::RX_IDLE;
						else if (st_q.rx_cnt == nbits - 4'h1)
						begin
							st_d.rx_st = asp_pkg::RX_IDLE;
							if (!st_q.ctrl[asp_pkg::CTL_RXD]
								&& (!st_q.ctrl[asp_pkg::CTL_MCE] || chk))
							begin
								st_d.rbuf = mode9 ? sh_n[8:1] : sh_n[9:2];
								st_d.ctrl[asp_pkg::CTL_RB8] = chk;
								rx_set = 1'b1;
							end
						end
					end
				end
			end
			default: st_d.rx_st = asp_pkg::RX_IDLE;
		endcase

		// Hardware sets win over a software clear in the same cycle.
		if (tx_set)
			st_d.ctrl[asp_pkg::CTL_TXD] = 1'b1;
		if (rx_set)
			st_d.ctrl[asp_pkg::CTL_RXD] = 1'b1;

		// Request follows the enabled flags, one cycle behind.
		st_d.irq = st_q.ie & (st_q.ctrl[asp_pkg::CTL_TXD]
			| st_q.ctrl[asp_pkg::CTL_RXD]);
	end

	// State register; line-facing flops reset to the idle-high level.
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_q       <= '0;
			st_q.ctrl  <= asp_pkg::CTRL_RST;
			st_q.rbuf  <= asp_pkg::DATA_RST;
			st_q.tx_st <= asp_pkg::TX_IDLE;
			st_q.rx_st <= asp_pkg::RX_IDLE;
			st_q.txd   <= 1'b1;
			st_q.tx_sh <= '1;
			st_q.rx1   <= 1'b1;
			st_q.rx2   <= 1'b1;
			st_q.rx3   <= 1'b1;
			st_q.pin1  <= 1'b1;
			st_q.pin2  <= 1'b1;
			st_q.pin3  <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign apb_o = st_q.rsp;
	assign txd_o = st_q.txd;
	assign irq_o = st_q.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_data_write;
		wr_data;
	endsequence

	sequence s_start_bit;
		tx_bit && st_q.tx_st == asp_pkg::TX_SEND && st_q.tx_cnt == 4'h0;
	endsequence

	a_data_write_start: assert property (s_data_write |=>
		st_q.tx_st == asp_pkg::TX_SEND && st_q.tx_cnt == 4'h0)
		else $error("Data write did not start a transmission.");

	a_start_bit_low: assert property (!wr_data throughout
		s_start_bit |=> !txd_o)
		else $error("Start bit was not driven low.");

	a_tx_flag_sticky: assert property (st_q.ctrl[asp_pkg::CTL_TXD]
		&& !wr_ctrl |=> st_q.ctrl[asp_pkg::CTL_TXD])
		else $error("Transmit done flag cleared by hardware.");

	a_rx_flag_sticky: assert property (st_q.ctrl[asp_pkg::CTL_RXD]
		&& !wr_ctrl |=> st_q.ctrl[asp_pkg::CTL_RXD])
		else $error("Receive done flag cleared by hardware.");

	a_irq_follows: assert property (##1 irq_o == $past(st_q.ie
		&& (st_q.ctrl[asp_pkg::CTL_TXD] || st_q.ctrl[asp_pkg::CTL_RXD])))
		else $error("Interrupt request does not follow the flags.");

	a_buffer_held: assert property (st_q.ctrl[asp_pkg::CTL_RXD]
		&& !wr_ctrl |=> $stable(st_q.rbuf))
		else $error("Receive buffer overwritten while flag set.");

	a_start_reload: assert property (rx_force |=>
		rx_count == $past(st_q.reload) && st_q.rx_st == asp_pkg::RX_BUSY)
		else $error("Start bit did not reload the receive timer.");

	a_read_buffer: assert property (apb_o.pready && !apb_i.pwrite
		&& apb_i.paddr == asp_pkg::OFS_DATA
		|-> apb_o.prdata == {24'h0, $past(st_q.rbuf)})
		else $error("Data read did not return the receive buffer.");

	a_tx_idle_high: assert property (st_q.tx_st == asp_pkg::TX_IDLE
		&& !wr_data [*2] |-> txd_o)
		else $error("Transmit line not idle high.");

	a_pready_one: assert property (apb_o.pready |=> !apb_o.pready)
		else $error("Ready held for more than one cycle.");
endmodule

// file: verif/asp_remote.sv
// Remote serial transceiver model that faces the port's serial pins.
`timescale 1ns/10ps
module asp_remote #(
	parameter int BIT_CLKS = 8
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	input  wire logic nine_i,
	output logic      rxd_o
);
	logic [8:0] got_data;
	logic       got_stop;
	int         got_cnt;

	// The line idles high, so a start bit is always a falling edge.
	initial
	begin
		rxd_o = 1'b1;
		got_data = '0;
		got_stop = 1'b0;
		got_cnt = 0;
	end

	// Sends start, data LSB first, optional ninth bit, then the stop level.
	// A low stop is only sent when a test asks for a bad stop bit.
	task automatic send(input logic [8:0] d, input logic nb, input logic stp);
		logic [10:0] f;
		int          n;
		f = nb ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
		n = nb ? 11 : 10;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
	endtask

	// Decodes each frame at mid-bit; the last bit is kept as the stop level.
	always
	begin
		@(negedge txd_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < (nine_i ? 10 : 9); i++)
		begin
			repeat (BIT_CLKS) @(posedge clk_i);
			if (i < (nine_i ? 9 : 8))
				got_data[i] = txd_i;
			else
				got_stop = txd_i;
		end
		if (!nine_i)
			got_data[8] = 1'b0;
		got_cnt++;
	end
endmodule

// file: verif/asp_top_tb.sv
// Self-checking bench for the serial port: registers, rates and frames.
`timescale 1ns/10ps
module asp_top_tb;
	logic                  clk_i;
	logic                  reset_i;
	asp_pkg::asp_apb_req_t apb_i;
	asp_pkg::asp_apb_rsp_t apb_o;
	logic                  rxd;
	logic                  txd_o;
	logic                  ext_osc;
	logic                  tmr_pin;
	logic                  irq_o;
	logic                  nine;
	logic [31:0]           rd;
	logic                  err;
	int                    num_errors = 0;
	int                    check_count = 0;
	int                    cyc = 0;
	int                    base;
	int                    w;
	int                    div [6] = '{1, 4, 12, 48, 48, 6};

	asp_top DUT (.clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i),
		.apb_o(apb_o), .rxd_i(rxd), .txd_o(txd_o), .ext_osc_i(ext_osc),
		.timer_one_ext_input_i(tmr_pin), .irq_o(irq_o));

	asp_remote #(.BIT_CLKS(8)) u_rem (.clk_i(clk_i), .txd_i(txd_o),
		.nine_i(nine), .rxd_o(rxd));

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Slow external sources, period six clocks, well under the sync limit.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0)
		begin
			ext_osc <= ~ext_osc;
			tmr_pin <= ~tmr_pin;
		end
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer; the request stands until pready is seen high.
	// Ready is looked at mid-cycle, where it has settled, so the edge that
	// follows is the one at which the slave takes the transfer.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		apb_i <= {1'b1, 1'b0, wr, a, d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		@(negedge clk_i);
		while (apb_o.pready !== 1'b1)
			@(negedge clk_i);
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		@(posedge clk_i);
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		check(rd, exp);
	endtask

	// Polls a register until the masked bits match, bounded in reads.
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v);
		for (int i = 0; i < 1000; i++)
		begin
			apb(1'b0, a, '0);
			if ((rd & m) === v)
				break;
		end
	endtask

	task automatic wait_frame(input int n);
		for (int i = 0; i < 3000 && u_rem.got_cnt != n; i++)
			@(posedge clk_i);
	endtask

	// Counts the clocks of a start bit; the data byte must begin with a one.
	task automatic width(output int n);
		n = 0;
		for (int i = 0; i < 4000 && txd_o !== 1'b0; i++)
			@(negedge clk_i);
		while (txd_o === 1'b0 && n < 4000)
		begin
			n++;
			@(negedge clk_i);
		end
	endtask

	initial
	begin
		apb_i = '0;
		reset_i = 1'b1;
		ext_osc = 1'b0;
		tmr_pin = 1'b0;
		nine = 1'b0;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		check(txd_o, 1'b1);
		rdchk(asp_pkg::OFS_CTRL, 32'h40);
		rdchk(asp_pkg::OFS_DATA, 32'h0);
		rdchk(asp_pkg::OFS_TCFG, 32'h0);
		rdchk(8'h10, 32'h0);
		check(err, 1'b1);
		apb(1'b1, asp_pkg::OFS_CTRL, 32'h0);
		rdchk(asp_pkg::OFS_CTRL, 32'h40);
		// Bit time is two overflows of 256 minus reload source ticks.
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b1, asp_pkg::OFS_TCFG, 32'h1fe | (k << 9));
			apb(1'b1, asp_pkg::OFS_DATA, 32'hff);
			width(w);
			check(w, 4 * div[k]);
			wait_reg(asp_pkg::OFS_STAT, 32'h100, 32'h0);
		end
		// Source code six, like seven, gives no clock, so the counter stands.
		apb(1'b1, asp_pkg::OFS_TCFG, 32'hdfe);
		apb(1'b0, asp_pkg::OFS_STAT, '0);
		base = rd & 32'hff;
		repeat (20) @(posedge clk_i);
		rdchk(asp_pkg::OFS_STAT, base);
		apb(1'b1, asp_pkg::OFS_TCFG, 32'h11fc);
		apb(1'b1, asp_pkg::OFS_CTRL, 32'h10);
		base = u_rem.got_cnt;
		apb(1'b1, asp_pkg::OFS_DATA, 32'ha5);
		wait_frame(base + 1);
		check(irq_o, 1'b1);
		check(u_rem.got_data, 32'ha5);
		check(u_rem.got_stop, 1'b1);
		rdchk(asp_pkg::OFS_CTRL, 32'h52);
		rdchk(asp_pkg::OFS_DATA, 32'h0);
		apb(1'b1, asp_pkg::OFS_CTRL, 32'h10);
		repeat (3) @(negedge clk_i);
		check(irq_o, 1'b0);
		u_rem.send(9'h03c, 1'b0, 1'b1);
		wait_reg(asp_pkg::OFS_CTRL, 32'h1, 32'h1);
		rdchk(asp_pkg::OFS_DATA, 32'h3c);
		rdchk(asp_pkg::OFS_CTRL, 32'h55);
		check(irq_o, 1'b1);
		// Second byte shifts in while the receive flag of the first is still set.
		fork
			u_rem.send(9'h096, 1'b0, 1'b1);
			begin
				repeat (24) @(posedge clk_i);
				rdchk(asp_pkg::OFS_CTRL, 32'h55);
				apb(1'b0, asp_pkg::OFS_STAT, '0);
				check(rd & 32'h300, 32'h200);
				apb(1'b1, asp_pkg::OFS_CTRL, 32'h10);
			end
		join
		wait_reg(asp_pkg::OFS_CTRL, 32'h1, 32'h1);
		rdchk(asp_pkg::OFS_DATA, 32'h96);
		u_rem.send(9'h021, 1'b0, 1'b1);
		repeat (8) @(posedge clk_i);
		rdchk(asp_pkg::OFS_DATA, 32'h96);
		apb(1'b1, asp_pkg::OFS_CTRL, 32'h30);
		u_rem.send(9'h044, 1'b0, 1'b0);
		repeat (8) @(posedge clk_i);
		rdchk(asp_pkg::OFS_CTRL, 32'h70);
		rdchk(asp_pkg::OFS_DATA, 32'h96);
		nine <= 1'b1;
		apb(1'b1, asp_pkg::OFS_CTRL, 32'hb8);
		u_rem.send(9'h11e, 1'b1, 1'b1);
		wait_reg(asp_pkg::OFS_CTRL, 32'h1, 32'h1);
		rdchk(asp_pkg::OFS_DATA, 32'h1e);
		rdchk(asp_pkg::OFS_CTRL, 32'hfd);
		apb(1'b1, asp_pkg::OFS_CTRL, 32'hb8);
		u_rem.send(9'h0e1, 1'b1, 1'b1);
		repeat (8) @(posedge clk_i);
		rdchk(asp_pkg::OFS_CTRL, 32'hf8);
		base = u_rem.got_cnt;
		apb(1'b1, asp_pkg::OFS_DATA, 32'h5a);
		wait_frame(base + 1);
		check(u_rem.got_data, 32'h15a);
		results();
	end
endmodule
